// File: rtl/pin_function_mux.sv
// Purpose : Function multiplexing of port B bits 0-4 and port A 0-1
// Assumes : Software select/direction arrive as plain registered ports
// Notes   : GPIO inputs are sampled once per enabled clock, no synchroniser needed
`timescale 1ns/1ps

// Operation
// - Full variant resets home pin to decoder
// - Home pin also timer, GPIO, clock monitor
// - Port B bit 3 resets to SPI clock
// - SPI clock output master, input slave
// - Port B bit 2 resets to SPI data-out
// - Master data leads sampling edge half period
// - Port B bit 1 resets to SPI data-in
// - Unselected slave floats its data output
// - Slave data leads master capture half period
// - Slave select marks transfer as received
// - Bits 1/0 carry async serial rx/tx
// - Each pin selectable as directional GPIO
// - Full variant resets port A to PWM
module pin_function_mux
  import pin_mux_pkg::*;
(
  input  wire logic             i_ref_clk,      // 10 MHz clock
  input  wire logic             i_rstn,         // Async reset, low
  input  wire logic             i_ce,           // Clock enable
  input  wire logic             i_variant,      // 1 = full variant
  input  wire logic             i_sel_we,       // Load new selects
  input  wire logic [13:0]      i_sel_wdata,    // 2 bits per pin
  input  wire logic [6:0]       i_gpio_dir,     // GPIO direction
  input  wire logic [6:0]       i_gpio_out,     // GPIO out values
  input  wire logic [6:0]       i_pin_in,       // Pin input levels
  input  wire logic             i_spi_master,   // SPI core is master
  input  wire logic             i_spi_sclk,     // SPI core clock out
  input  wire logic             i_spi_mosi,     // SPI core data out
  input  wire logic             i_spi_miso,     // SPI core slave data
  input  wire logic             i_async_tx,     // Serial 1 tx data
  input  wire logic             i_timer_a3_o,   // Timer ch3 out value
  input  wire logic             i_timer_a3_oe,  // Timer ch3 drives
  input  wire logic             i_presc_clk,    // Prescaler clock mon
  input  wire logic             i_clkout_en,    // Clock-out select on
  input  wire logic             i_pwm_a0,       // PWM output 0
  input  wire logic             i_pwm_a1,       // PWM output 1
  output logic [6:0]            o_pin_oe,       // Pin drive enables
  output logic [6:0]            o_pin_o,        // Pin drive values
  output logic [13:0]           o_sel,          // Current selects
  output logic                  o_quad_home,    // Decoder home input
  output logic                  o_timer_a3_in,  // Timer ch3 input
  output logic                  o_spi_sclk_in,  // SPI clock in
  output logic                  o_spi_mosi_in,  // SPI data-out pin in
  output logic                  o_spi_miso_in,  // SPI data-in pin in
  output logic                  o_spi_selected, // SPI slave selected
  output logic                  o_async_rx,     // Serial 1 rx data
  output logic [6:0]            o_gpio_in       // GPIO input values
);

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic [1:0] rst_sync_q;                       // Release flops
  logic       rst_n;                            // Synced reset

  // Two-flop release keeps deassertion glitch free
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'h1};
  end
  assign rst_n = rst_sync_q[1];

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {ST_RESET, ST_DEFAULT, ST_RUN} mux_st_t;

  typedef struct packed {
    mux_st_t     st;                            // Init state
    logic [13:0] sel;                           // Per-pin selects
    logic [6:0]  gpio_in;                       // Sampled GPIO inputs
  } state_t;

  state_t s_q;                                  // Registered state
  state_t s_d;                                  // Next state

  // Reset defaults per variant; reduced part gets unusable code on home and PWM pins
  function automatic logic [13:0] default_sel(input logic full);
    logic [13:0] v;
    v = '0;
    // Port B bits 0-3 default to the SPI functions on both parts
    v[PIN_B0*SEL_W +: SEL_W] = FN_PRIMARY;
    v[PIN_B1*SEL_W +: SEL_W] = FN_PRIMARY;
    v[PIN_B2*SEL_W +: SEL_W] = FN_PRIMARY;
    v[PIN_B3*SEL_W +: SEL_W] = FN_PRIMARY;
    // Home and PWM pins depend on the variant
    v[PIN_B4*SEL_W +: SEL_W] = full ? FN_PRIMARY : FN_UNUSABLE;
    v[PIN_A0*SEL_W +: SEL_W] = full ? FN_PRIMARY : FN_UNUSABLE;
    v[PIN_A1*SEL_W +: SEL_W] = full ? FN_PRIMARY : FN_UNUSABLE;
    return v;
  endfunction : default_sel

  // Next-state logic
  always_comb
  begin
    s_d = s_q;
    if (i_ce)
    begin
      s_d.gpio_in = i_pin_in;
      case (s_q.st)
        ST_RESET:
        begin
          // Variant level caught after release, not under reset
          s_d.sel = default_sel(i_variant);
          s_d.st  = ST_DEFAULT;
        end
        ST_DEFAULT, ST_RUN:
        begin
          // Software reprograms selects
          if (i_sel_we)
          begin
            s_d.sel = i_sel_wdata;
            s_d.st  = ST_RUN;
          end
        end
        default:
          s_d.st = ST_RESET;
      endcase
    end
  end

  // State register
  always_ff @(posedge i_ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '{st: ST_RESET, sel: 14'h0000, gpio_in: 7'h00};
    else
      s_q <= s_d;
  end

  // ---------------------------------------------------------------
  // SPI pin roles
  // ---------------------------------------------------------------
  logic sclk_oe, sclk_o, mosi_oe, mosi_o, miso_oe, miso_o;
  logic sel_active;                             // Select pin in use

  assign sel_active = (s_q.sel[PIN_B0*SEL_W +: SEL_W] == FN_PRIMARY);

  spi_pin_role u_spi_role (
    .i_master    (i_spi_master),
    .i_sclk_core (i_spi_sclk),
    .i_mosi_core (i_spi_mosi),
    .i_miso_core (i_spi_miso),
    .i_sel_in    (sel_active ? i_pin_in[PIN_B0] : 1'h1),
    .o_sclk_oe   (sclk_oe),
    .o_sclk_o    (sclk_o),
    .o_mosi_oe   (mosi_oe),
    .o_mosi_o    (mosi_o),
    .o_miso_oe   (miso_oe),
    .o_miso_o    (miso_o),
    .o_selected  (o_spi_selected)
  );

  // ---------------------------------------------------------------
  // Per-pin function tables and cells
  // ---------------------------------------------------------------
  logic [3:0] fn_oe [NUM_PINS];                 // Slot output enables
  logic [3:0] fn_o  [NUM_PINS];                 // Slot output values

  // Slots: {alt2, alt1, gpio, primary}; gpio slot handled in cell
  always_comb
  begin
    // Bit 0: select input / serial tx
    fn_oe[PIN_B0] = {1'h0, 1'h1, 1'h0, 1'h0};
    fn_o[PIN_B0]  = {1'h0, i_async_tx, 1'h0, 1'h0};
    // Bit 1: SPI data-in / serial rx
    fn_oe[PIN_B1] = {1'h0, 1'h0, 1'h0, miso_oe};
    fn_o[PIN_B1]  = {1'h0, 1'h0, 1'h0, miso_o};
    // Bit 2: SPI data-out
    fn_oe[PIN_B2] = {1'h0, 1'h0, 1'h0, mosi_oe};
    fn_o[PIN_B2]  = {1'h0, 1'h0, 1'h0, mosi_o};
    // Bit 3: SPI clock
    fn_oe[PIN_B3] = {1'h0, 1'h0, 1'h0, sclk_oe};
    fn_o[PIN_B3]  = {1'h0, 1'h0, 1'h0, sclk_o};
    // Bit 4: home / timer ch3 / clock monitor
    fn_oe[PIN_B4] = {i_clkout_en, i_timer_a3_oe, 1'h0, 1'h0};
    fn_o[PIN_B4]  = {i_presc_clk, i_timer_a3_o, 1'h0, 1'h0};
    // Port A: PWM outputs
    fn_oe[PIN_A0] = {1'h0, 1'h0, 1'h0, 1'h1};
    fn_o[PIN_A0]  = {1'h0, 1'h0, 1'h0, i_pwm_a0};
    fn_oe[PIN_A1] = {1'h0, 1'h0, 1'h0, 1'h1};
    fn_o[PIN_A1]  = {1'h0, 1'h0, 1'h0, i_pwm_a1};
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++)
    begin : g_pin
      pin_cell u_cell (
        .i_sel      (s_q.sel[gi*SEL_W +: SEL_W]),
        .i_fn_oe    (fn_oe[gi]),
        .i_fn_o     (fn_o[gi]),
        .i_gpio_dir (i_gpio_dir[gi]),
        .i_gpio_o   (i_gpio_out[gi]),
        .o_oe       (o_pin_oe[gi]),
        .o_o        (o_pin_o[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Input routing
  // ---------------------------------------------------------------
  // Inputs follow the select; idle value when not routed
  always_comb
  begin
    o_quad_home   = (s_q.sel[PIN_B4*SEL_W +: SEL_W] == FN_PRIMARY)
                    ? i_pin_in[PIN_B4] : 1'h0;
    o_timer_a3_in = (s_q.sel[PIN_B4*SEL_W +: SEL_W] == FN_ALT1)
                    ? i_pin_in[PIN_B4] : 1'h0;
    o_spi_sclk_in = (s_q.sel[PIN_B3*SEL_W +: SEL_W] == FN_PRIMARY)
                    ? i_pin_in[PIN_B3] : 1'h0;
    o_spi_mosi_in = (s_q.sel[PIN_B2*SEL_W +: SEL_W] == FN_PRIMARY)
                    ? i_pin_in[PIN_B2] : 1'h0;
    o_spi_miso_in = (s_q.sel[PIN_B1*SEL_W +: SEL_W] == FN_PRIMARY)
                    ? i_pin_in[PIN_B1] : 1'h0;
    // Serial line idles high when not routed
    o_async_rx    = (s_q.sel[PIN_B1*SEL_W +: SEL_W] == FN_ALT1)
                    ? i_pin_in[PIN_B1] : 1'h1;
  end

  assign o_sel     = s_q.sel;
  assign o_gpio_in = s_q.gpio_in;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_home_default: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    (s_q.st == ST_RESET && i_ce && i_variant)
      |=> s_q.sel[PIN_B4*SEL_W +: SEL_W] == FN_PRIMARY)
    else $error("home pin not default after reset");

  a_reduced_default: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    (s_q.st == ST_RESET && i_ce && !i_variant)
      |=> s_q.sel[PIN_A0*SEL_W +: SEL_W] == FN_UNUSABLE)
    else $error("reduced part default usable");

  a_spi_defaults: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    (s_q.st == ST_RESET && i_ce) |=> s_q.sel[7:0] == 8'h00)
    else $error("spi pins not default after reset");

  a_sclk_master: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    (s_q.sel[PIN_B3*SEL_W +: SEL_W] == FN_PRIMARY)
      |-> o_pin_oe[PIN_B3] == i_spi_master)
    else $error("spi clock direction wrong");

  a_miso_float: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    (s_q.sel[PIN_B1*SEL_W +: SEL_W] == FN_PRIMARY && !o_spi_selected)
      |-> !o_pin_oe[PIN_B1])
    else $error("unselected slave drives data");

  a_select_recv: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    o_spi_selected |-> !i_spi_master && !i_pin_in[PIN_B0])
    else $error("selected without select low");

  a_tx_route: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    (s_q.sel[PIN_B0*SEL_W +: SEL_W] == FN_ALT1)
      |-> o_pin_oe[PIN_B0] && o_pin_o[PIN_B0] == i_async_tx)
    else $error("serial tx not routed");

  a_gpio_dir: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    (s_q.sel[PIN_B2*SEL_W +: SEL_W] == FN_GPIO)
      |-> o_pin_oe[PIN_B2] == i_gpio_dir[PIN_B2])
    else $error("gpio direction ignored");

  a_sel_load: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    (s_q.st != ST_RESET && i_ce && i_sel_we) |=> o_sel == $past(i_sel_wdata))
    else $error("select write lost");

  a_timer_route: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    (s_q.sel[PIN_B4*SEL_W +: SEL_W] == FN_ALT1)
      |-> o_pin_oe[PIN_B4] == i_timer_a3_oe
          && o_timer_a3_in == i_pin_in[PIN_B4])
    else $error("timer channel not routed");

  a_pwm_drive: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    (s_q.sel[PIN_A0*SEL_W +: SEL_W] == FN_PRIMARY)
      |-> o_pin_oe[PIN_A0] && o_pin_o[PIN_A0] == i_pwm_a0)
    else $error("pwm output not driven");

  a_rx_route: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    (s_q.sel[PIN_B1*SEL_W +: SEL_W] == FN_ALT1)
      |-> !o_pin_oe[PIN_B1] && o_async_rx == i_pin_in[PIN_B1])
    else $error("serial rx not routed");

  // A write offered while disabled must be dropped, not queued
  a_ce_freeze: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    !i_ce |=> o_sel == $past(o_sel))
    else $error("select moved while disabled");

  c_reduced_boot: cover property (@(posedge i_ref_clk) disable iff (!rst_n)
    s_q.st == ST_RESET && i_ce && !i_variant);
  c_reprogram: cover property (@(posedge i_ref_clk) disable iff (!rst_n)
    s_q.st == ST_DEFAULT && i_ce && i_sel_we);
  c_slave_sel: cover property (@(posedge i_ref_clk) disable iff (!rst_n)
    o_spi_selected && o_pin_oe[PIN_B1]);
  c_clock_mon: cover property (@(posedge i_ref_clk) disable iff (!rst_n)
    s_q.sel[PIN_B4*SEL_W +: SEL_W] == FN_ALT2 && i_clkout_en);

endmodule : pin_function_mux

// File: rtl/pin_mux_pkg.sv
// Purpose : Shared constants for the port B / port A pin function mux
// Assumes : Seven shared pins, per-pin 2-bit function select
// Notes   : Function codes are shared, their meaning differs per pin; see the per-pin slot tables in pin_function_mux
package pin_mux_pkg;

  // ---------------------------------------------------------------
  // Pin indices
  // ---------------------------------------------------------------
  localparam int unsigned NUM_PINS   = 7;     // Shared pins handled
  localparam int unsigned PIN_B0     = 0;     // Port B bit 0
  localparam int unsigned PIN_B1     = 1;     // Port B bit 1
  localparam int unsigned PIN_B2     = 2;     // Port B bit 2
  localparam int unsigned PIN_B3     = 3;     // Port B bit 3
  localparam int unsigned PIN_B4     = 4;     // Port B bit 4
  localparam int unsigned PIN_A0     = 5;     // Port A bit 0
  localparam int unsigned PIN_A1     = 6;     // Port A bit 1
  localparam int unsigned SEL_W      = 2;     // Select field width
  localparam int unsigned SEL_ALL_W  = 14;    // NUM_PINS * SEL_W

  // ---------------------------------------------------------------
  // Function codes
  // ---------------------------------------------------------------
  localparam logic [1:0] FN_PRIMARY  = 2'h0;  // Pin's primary function
  localparam logic [1:0] FN_GPIO     = 2'h1;  // General-purpose I/O
  localparam logic [1:0] FN_ALT1     = 2'h2;  // First alternate
  localparam logic [1:0] FN_ALT2     = 2'h3;  // Second alternate
  // Reduced variant: reset select points at no offered function on port A; on bit 4 it is the ALT2 clock monitor
  localparam logic [1:0] FN_UNUSABLE = 2'h3;

  // Variant codes
  localparam logic VARIANT_FULL      = 1'h1;  // Full-featured part
  localparam logic VARIANT_REDUCED   = 1'h0;  // Reduced part

  // Reset synchroniser depth
  localparam int unsigned RST_STAGES = 2;     // Release flops

endpackage : pin_mux_pkg

// File: rtl/spi_pin_role.sv
// Purpose : Direction and drive of the serial-interface-0 pins
// Assumes : Role and select levels synchronous to i_ref_clk
// Notes   : Purely combinational; data timing is the core's concern
`timescale 1ns/1ps
module spi_pin_role
  import pin_mux_pkg::*;
(
  input  wire logic i_master,        // Core is master
  input  wire logic i_sclk_core,     // Core serial clock out
  input  wire logic i_mosi_core,     // Core master-out data
  input  wire logic i_miso_core,     // Core slave-out data
  input  wire logic i_sel_in,        // Select pin level, low = selected
  output logic      o_sclk_oe,       // Drive clock pin
  output logic      o_sclk_o,        // Clock pin value
  output logic      o_mosi_oe,       // Drive data-out pin
  output logic      o_mosi_o,        // Data-out pin value
  output logic      o_miso_oe,       // Drive data-in pin
  output logic      o_miso_o,        // Data-in pin value
  output logic      o_selected       // Slave transfer addressed here
);

  // ---------------------------------------------------------------
  // Role decode
  // ---------------------------------------------------------------
  // Clock out as master, clock input as slave
  always_comb
  begin
    o_sclk_oe  = i_master;
    o_sclk_o   = i_sclk_core;
    // Master drives data-out; core already leads by half a clock
    o_mosi_oe  = i_master;
    o_mosi_o   = i_mosi_core;
    // Slave select gates reception
    o_selected = ~i_master & ~i_sel_in;
    // Unselected slave floats its output
    o_miso_oe  = o_selected;
    o_miso_o   = i_miso_core;
  end

endmodule : spi_pin_role

// File: rtl/pin_cell.sv
// Purpose : One shared pin: function select and GPIO direction
// Assumes : Four function slots per pin, slot 1 is always GPIO
// Notes   : GPIO direction only matters with the GPIO function
`timescale 1ns/1ps
module pin_cell
  import pin_mux_pkg::*;
(
  input  wire logic [1:0] i_sel,     // Active function select
  input  wire logic [3:0] i_fn_oe,   // Per-function output enable
  input  wire logic [3:0] i_fn_o,    // Per-function output value
  input  wire logic       i_gpio_dir,// GPIO direction, 1 = output
  input  wire logic       i_gpio_o,  // GPIO output value
  output logic            o_oe,      // Pin output enable
  output logic            o_o        // Pin output value
);

  // ---------------------------------------------------------------
  // Output select
  // ---------------------------------------------------------------
  always_comb
  begin
    if (i_sel == FN_GPIO)
    begin
      // Direction only counts in GPIO mode
      o_oe = i_gpio_dir;
      o_o  = i_gpio_o;
    end
    else
    begin
      o_oe = i_fn_oe[i_sel];
      o_o  = i_fn_o[i_sel];
    end
  end

endmodule : pin_cell

// File: verification/pin_peer_model.sv
// Purpose : Board side of the shared pins: peers, encoder, pull-ups
// Assumes : Device drive wins; released lines rise through pull-ups
// Notes   : Peer slave only talks on the data-in pin when selected
`timescale 1ns/1ps
module pin_peer_model
(
  input  wire logic [6:0] i_dev_oe,     // Device drive enables
  input  wire logic [6:0] i_dev_o,      // Device drive values
  input  wire logic [6:0] i_board_oe,   // Board sources drive
  input  wire logic [6:0] i_board_o,    // Board source values
  input  wire logic       i_peer_sel_n, // Peer slave selected, low
  input  wire logic       i_peer_miso,  // Peer slave data
  output logic      [6:0] o_pin         // Resolved pin levels
);
  // ---------------------------------------------------------------
  // Wire resolution
  // ---------------------------------------------------------------
  // Pull-up instead of a stale value, so a float never reads as data
  always_comb
  begin
    for (int k = 0; k < 7; k++)
    begin
      o_pin[k] = i_dev_oe[k] ? i_dev_o[k] :
                 (i_board_oe[k] ? i_board_o[k] : 1'h1);
    end
    // Unselected peer floats its data line
    if (!i_dev_oe[1] && !i_peer_sel_n)
    begin
      o_pin[1] = i_peer_miso;
    end
  end
endmodule : pin_peer_model

// File: verification/port_b_a_pin_function_mux_tb.sv
// Purpose : Self-checking bench of the shared pin function mux
// Assumes : Selects load one cycle after a taken write
// Notes   : Random traffic from a fixed seed plus both reset variants
`timescale 1ns/1ps
module port_b_a_pin_function_mux_tb;
  import pin_mux_pkg::*;
  logic        ref_clk, rstn, ce, variant, sel_we;
  logic [13:0] sel_wdata, exp_sel;
  logic [6:0]  gpio_dir, gpio_out, board_oe, board_o, exp_gin;
  logic        spi_master, spi_sclk, spi_mosi, spi_miso, async_tx;
  logic        tmr_o, tmr_oe, presc_clk, clkout_en, pwm_a0, pwm_a1;
  logic        peer_sel_n, peer_miso, armed, quad_home, async_rx, spi_sel;
  logic        tmr_in, sclk_in, mosi_in, miso_in;
  logic [1:0]  rel;
  logic [6:0]  pin, pin_oe, pin_o, gpio_in;
  logic [13:0] sel;
  logic [63:0] r;
  integer      seed, fails, checked;

  pin_function_mux dut (.i_ref_clk(ref_clk), .i_rstn(rstn), .i_ce(ce),
    .i_variant(variant), .i_sel_we(sel_we), .i_sel_wdata(sel_wdata),
    .i_gpio_dir(gpio_dir), .i_gpio_out(gpio_out), .i_pin_in(pin),
    .i_spi_master(spi_master), .i_spi_sclk(spi_sclk),
    .i_spi_mosi(spi_mosi), .i_spi_miso(spi_miso), .i_async_tx(async_tx),
    .i_timer_a3_o(tmr_o), .i_timer_a3_oe(tmr_oe), .i_presc_clk(presc_clk),
    .i_clkout_en(clkout_en), .i_pwm_a0(pwm_a0), .i_pwm_a1(pwm_a1),
    .o_pin_oe(pin_oe), .o_pin_o(pin_o), .o_sel(sel),
    .o_quad_home(quad_home), .o_timer_a3_in(tmr_in), .o_spi_sclk_in(sclk_in),
    .o_spi_mosi_in(mosi_in), .o_spi_miso_in(miso_in),
    .o_spi_selected(spi_sel),
    .o_async_rx(async_rx), .o_gpio_in(gpio_in));

  pin_peer_model peer (.i_dev_oe(pin_oe), .i_dev_o(pin_o),
    .i_board_oe(board_oe), .i_board_o(board_o),
    .i_peer_sel_n(peer_sel_n), .i_peer_miso(peer_miso), .o_pin(pin));

  // ---------------------------------------------------------------
  // Clock, reference model of selects and input sampling
  // ---------------------------------------------------------------
  initial
  begin
    ref_clk = 1'h0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Old input values are seen here, before the bench's updates land;
  // two-edge release and the ignored default-load write are modelled
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rel     <= 2'h0;
      armed   <= 1'h0;
      exp_sel <= 14'h0000;
      exp_gin <= 7'h00;
    end
    else
    begin
      rel <= {rel[0], 1'h1};
      if (rel[1] && ce)
      begin
        exp_gin <= pin;
        armed   <= 1'h1;
        if (!armed)
          exp_sel <= (variant == VARIANT_FULL) ? 14'h0000 : 14'h3F00;
        else if (sel_we)
          exp_sel <= sel_wdata;
      end
    end
  end

  // Expected drive {enables, values masked by enables}
  function automatic logic [13:0] exp_pins(input logic [13:0] s);
    logic [6:0] oe;
    logic [6:0] o;
    begin
      oe = 7'h00;
      o = 7'h00;
      for (int k = 0; k < 7; k++)
        if (s[2*k +: 2] == FN_GPIO)
          {oe[k], o[k]} = {gpio_dir[k], gpio_out[k]};
      if (s[1:0] == FN_ALT1)
        {oe[0], o[0]} = {1'h1, async_tx};
      if (s[3:2] == FN_PRIMARY)
        {oe[1], o[1]} = {!spi_master && !pin[0] && s[1:0] == FN_PRIMARY,
                         spi_miso};
      if (s[5:4] == FN_PRIMARY)
        {oe[2], o[2]} = {spi_master, spi_mosi};
      if (s[7:6] == FN_PRIMARY)
        {oe[3], o[3]} = {spi_master, spi_sclk};
      if (s[9:8] == FN_ALT1)
        {oe[4], o[4]} = {tmr_oe, tmr_o};
      if (s[9:8] == FN_ALT2)
        {oe[4], o[4]} = {clkout_en, presc_clk};
      if (s[11:10] == FN_PRIMARY)
        {oe[5], o[5]} = {1'h1, pwm_a0};
      if (s[13:12] == FN_PRIMARY)
        {oe[6], o[6]} = {1'h1, pwm_a1};
      return {oe, o & oe};
    end
  endfunction : exp_pins

  // ---------------------------------------------------------------
  // Compare and closing tasks
  // ---------------------------------------------------------------
  task automatic chk_word(input logic [13:0] got, input logic [13:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic summarize;
    if (fails == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  // Settled outputs checked mid-cycle, away from the sampling edge
  task automatic check_all;
    @(negedge ref_clk);
    chk_word(sel, exp_sel);
    chk_word({pin_oe, pin_o & pin_oe}, exp_pins(exp_sel));
    chk_bit(quad_home, exp_sel[9:8] == FN_PRIMARY ? pin[4] : 1'h0);
    chk_bit(async_rx, exp_sel[3:2] == FN_ALT1 ? pin[1] : 1'h1);
    chk_bit(spi_sel, !spi_master && !pin[0] && exp_sel[1:0] == 2'h0);
    chk_bit(tmr_in, exp_sel[9:8] == FN_ALT1 ? pin[4] : 1'h0);
    chk_bit(sclk_in, exp_sel[7:6] == FN_PRIMARY ? pin[3] : 1'h0);
    chk_bit(mosi_in, exp_sel[5:4] == FN_PRIMARY ? pin[2] : 1'h0);
    chk_bit(miso_in, exp_sel[3:2] == FN_PRIMARY ? pin[1] : 1'h0);
    chk_word({7'h00, gpio_in}, {7'h00, exp_gin});
  endtask : check_all

  // Reset of one variant; defaults hold until the first write
  task automatic do_reset(input logic v, input logic [13:0] dflt);
    @(posedge ref_clk);
    rstn <= 1'h0;
    variant <= v;
    ce <= 1'h1;
    sel_we <= 1'h0;
    repeat (10) @(posedge ref_clk);
    rstn <= 1'h1;
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    chk_word(sel, dflt);
  endtask : do_reset

  // Random traffic, every input except reset and variant reached each cycle
  task automatic rand_run(input int n);
    repeat (n)
    begin
      @(posedge ref_clk);
      r = {$random(seed), $random(seed)};
      ce <= r[0] | r[1];
      sel_we <= r[2];
      sel_wdata <= r[16:3];
      {gpio_dir, gpio_out} <= r[30:17];
      {spi_master, spi_sclk, spi_mosi, spi_miso} <= r[34:31];
      {async_tx, tmr_o, tmr_oe, presc_clk, clkout_en} <= r[39:35];
      {pwm_a0, pwm_a1, board_oe, board_o} <= r[55:40];
      {peer_sel_n, peer_miso} <= r[57:56];
      check_all;
    end
  endtask : rand_run

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    seed = 90;
    fails = 0;
    checked = 0;
    {rstn, ce, variant, sel_we, sel_wdata, gpio_dir, gpio_out} = '0;
    {spi_master, spi_sclk, spi_mosi, spi_miso, async_tx} = '0;
    {tmr_o, tmr_oe, presc_clk, clkout_en, pwm_a0, pwm_a1} = '0;
    {board_oe, board_o, peer_miso} = '0;
    peer_sel_n = 1'h1;
    do_reset(VARIANT_FULL, 14'h0000);
    check_all;
    rand_run(400);
    do_reset(VARIANT_REDUCED, 14'h3F00);
    check_all;
    // Software reprograms the unusable defaults before use
    @(posedge ref_clk);
    sel_we <= 1'h1;
    sel_wdata <= 14'h0000;
    @(posedge ref_clk);
    sel_we <= 1'h0;
    check_all;
    rand_run(400);
    summarize;
  end

  // Hang guard
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    fails++;
    summarize;
  end
endmodule : port_b_a_pin_function_mux_tb
